// file: hdl/nor_erase_suspend_sequencer.sv
// Contract
// - raise high voltage only with blocks unprotected
// - high voltage only for accelerated program, chip erase; the code has no accelerated program and also lets polling and read/reset out
// - chip erase takes six write cycles
// - after failure issue read/reset, then verify blocks
// - bypass chip erase takes two write cycles
// - block erase six cycles, repeat sixth adds
// - bypass block erase two cycles, repeat second adds
// - erase suspend is one write, address ignored
`timescale 1ns/1ps
`include "nor_seq_cfg.svh"
module nor_erase_suspend_sequencer (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // flash pins
   input wire logic [`FL_DW-1:0] fl_dq_i,
   output nor_seq_pkg::pins_t fl_pins,
   output logic fl_vhh_en
);
   import nor_seq_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // one bus cycle of a command sequence
   function automatic bus_step_t step_of(op_t op, logic [2:0] idx, logic byp,
                                         logic [`FL_AW-1:0] blk);
      bus_step_t s;
      s = '{addr: `ADR_UNLK1, data: `CMD_RESET, we: 1'b1, last: 1'b1};
      case (op)
         OP_CHIP, OP_BLOCK: begin
            if (byp) begin
               s.data = (idx == 3'h0) ? `CMD_ERASE_SETUP :
                        ((op == OP_CHIP) ? `CMD_CHIP : `CMD_BLOCK);
               if (op == OP_BLOCK && idx == 3'h1) begin
                  s.addr = blk;
               end
               s.last = (idx == 3'h1);
            end else begin
               case (idx)
                  3'h0, 3'h3: s.data = `CMD_UNLK1;
                  3'h1, 3'h4: begin
                     s.addr = `ADR_UNLK2;
                     s.data = `CMD_UNLK2;
                  end
                  3'h2: s.data = `CMD_ERASE_SETUP;
                  default: begin
                     s.data = (op == OP_CHIP) ? `CMD_CHIP : `CMD_BLOCK;
                     s.addr = (op == OP_CHIP) ? `ADR_UNLK1 : blk;
                  end
               endcase
               s.last = (idx == 3'h5);
            end
         end
         OP_ADD: begin
            // same cycle serves normal and bypass lists
            s.addr = blk;
            s.data = `CMD_BLOCK;
         end
         OP_ESUSP, OP_PSUSP: begin
            s.addr = blk;
            s.data = `CMD_SUSPEND;
         end
         OP_RESUME: begin
            s.addr = blk;
            s.data = `CMD_RESUME;
         end
         OP_POLL: begin
            s.addr = blk;
            s.we = 1'b0;
         end
         default: s.data = `CMD_RESET;
      endcase
      return s;
   endfunction

   // with high voltage up only chip erase, polling and reset may go out
   function automatic logic op_ok(op_t op, logic high_voltage_level);
      logic ok;
      ok = (op >= OP_CHIP) && (op <= OP_POLL);
      if (high_voltage_level) begin
         ok = (op == OP_CHIP) || (op == OP_POLL) || (op == OP_RESET);
      end
      return ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   seq_state_t st_q, st_d;
   op_t op_q, op_d;
   logic [2:0] ctrl_q, ctrl_d;
   logic [2:0] idx_q, idx_d;
   logic [2:0] wcnt_q, wcnt_d;
   logic [`FL_AW-1:0] addr_q, addr_d;
   logic [`FL_AW-1:0] blk_q, blk_d;
   logic [`FL_DW-1:0] rdat_q, rdat_d;
   logic byp_q, byp_d;
   logic vhh_d;
   logic refused_q, refused_d;
   logic start_q, start_d;
   logic fin_q, fin_d;
   logic [31:0] rdata_d;
   logic cmd_wr, take, refuse;
   op_t new_op;
   bus_step_t step;
   logic eng_done;
   logic [`FL_DW-1:0] eng_rdata;

   assign cmd_wr = reg_wr && (reg_addr == `REG_CMD);
   assign new_op = op_t'(reg_wdata[3:0]);
   // no queue: a command while busy is refused, not held
   assign take = cmd_wr && (st_q == S_IDLE) && op_ok(new_op, fl_vhh_en);
   assign refuse = cmd_wr && !take;

   always_comb begin
      step = step_of(op_q, idx_q, byp_q, blk_q);
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_d = st_q;
      op_d = op_q;
      idx_d = idx_q;
      wcnt_d = wcnt_q;
      blk_d = blk_q;
      byp_d = byp_q;
      rdat_d = rdat_q;
      vhh_d = fl_vhh_en;
      start_d = 1'b0;
      fin_d = 1'b0;
      ctrl_d = ctrl_q;
      addr_d = addr_q;
      refused_d = refused_q;
      rdata_d = 32'h00000000;
      case (st_q)
         S_IDLE: begin
            // voltage moves only between operations, never during one
            if (!take) begin
               vhh_d = ctrl_q[`CTRL_VHH] & ctrl_q[`CTRL_UNPROT];
            end
            if (take) begin
               op_d = new_op;
               idx_d = 3'h0;
               wcnt_d = 3'h0;
               blk_d = addr_q;
               byp_d = ctrl_q[`CTRL_BYP] | fl_vhh_en;
               st_d = S_LAUNCH;
            end
         end
         S_LAUNCH: begin
            start_d = 1'b1;
            wcnt_d = wcnt_q + {2'h0, step.we};
            st_d = S_WAIT;
         end
         S_WAIT: begin
            if (eng_done) begin
               if (step.last) begin
                  if (!step.we) begin
                     rdat_d = eng_rdata;
                  end
                  fin_d = 1'b1;
                  st_d = S_IDLE;
               end else begin
                  idx_d = idx_q + 3'h1;
                  st_d = S_LAUNCH;
               end
            end
         end
         default: st_d = S_IDLE;
      endcase
      if (reg_wr && reg_addr == `REG_CTRL) begin
         ctrl_d = reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == `REG_ADDR) begin
         addr_d = reg_wdata[`FL_AW-1:0];
      end
      // a new refusal wins over a clear in the same cycle
      refused_d = (refused_q & ~(reg_wr && reg_addr == `REG_STATUS
                                 && reg_wdata[`ST_REFUSED])) | refuse;
      if (reg_rd) begin
         case (reg_addr)
            `REG_CTRL: rdata_d = {29'h0, ctrl_q};
            `REG_CMD: rdata_d = {28'h0, op_q};
            `REG_ADDR: rdata_d = {7'h0, addr_q};
            `REG_STATUS: rdata_d = {26'h0, rdat_q[`DQ_POLL], rdat_q[`DQ_TOG],
                                    rdat_q[`DQ_TMR], refused_q, fl_vhh_en,
                                    st_q != S_IDLE};
            `REG_DATA: rdata_d = {16'h0, rdat_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= S_IDLE;
         op_q <= OP_NONE;
         idx_q <= 3'h0;
         wcnt_q <= 3'h0;
         blk_q <= '0;
         byp_q <= 1'b0;
         rdat_q <= '0;
         fl_vhh_en <= 1'b0;
         start_q <= 1'b0;
         fin_q <= 1'b0;
         ctrl_q <= `CTRL_RESET;
         addr_q <= '0;
         refused_q <= 1'b0;
         reg_rdata <= 32'h00000000;
      end else begin
         st_q <= st_d;
         op_q <= op_d;
         idx_q <= idx_d;
         wcnt_q <= wcnt_d;
         blk_q <= blk_d;
         byp_q <= byp_d;
         rdat_q <= rdat_d;
         fl_vhh_en <= vhh_d;
         start_q <= start_d;
         fin_q <= fin_d;
         ctrl_q <= ctrl_d;
         addr_q <= addr_d;
         refused_q <= refused_d;
         reg_rdata <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   bus_cycle_engine u_eng (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(start_q),
      .step(step),
      .done(eng_done),
      .rdata(eng_rdata),
      .dq_i(fl_dq_i),
      .pins(fl_pins)
   );

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   chk_chip_six_writes: assert property (
      fin_q && op_q == OP_CHIP && !byp_q |-> wcnt_q == 3'h6)
      else $error("chip erase did not use six writes");
   chk_chip_bypass_two: assert property (
      fin_q && op_q == OP_CHIP && byp_q |-> wcnt_q == 3'h2)
      else $error("bypass chip erase did not use two writes");
   chk_block_six_writes: assert property (
      fin_q && op_q == OP_BLOCK && !byp_q |-> wcnt_q == 3'h6)
      else $error("block erase did not use six writes");
   chk_block_bypass_two: assert property (
      fin_q && op_q == OP_BLOCK && byp_q |-> wcnt_q == 3'h2)
      else $error("bypass block erase did not use two writes");
   chk_suspend_one_write: assert property (
      $fell(fl_pins.we_n) && op_q == OP_ESUSP |->
         fl_pins.dq_oe && fl_pins.dq_o == `CMD_SUSPEND ##[1:400] fin_q && wcnt_q == 3'h1)
      else $error("erase suspend is not one write of B0h");
   chk_resume_code: assert property (
      $fell(fl_pins.we_n) && op_q == OP_RESUME |-> fl_pins.dq_o == `CMD_RESUME)
      else $error("resume write carries the wrong code");
   chk_reset_code: assert property (
      $fell(fl_pins.we_n) && op_q == OP_RESET |-> fl_pins.dq_o == `CMD_RESET)
      else $error("read/reset write carries the wrong code");
   chk_vhh_unprot: assert property (
      $rose(fl_vhh_en) |-> $past(ctrl_q[`CTRL_UNPROT]) && $past(st_q) == S_IDLE)
      else $error("high voltage raised without unprotect confirmation");
   chk_vhh_steady: assert property (
      st_q != S_IDLE && $past(st_q) != S_IDLE |-> $stable(fl_vhh_en))
      else $error("high voltage moved during an operation");
   chk_vhh_ops: assert property (
      fl_vhh_en && st_q != S_IDLE |-> op_q inside {OP_CHIP, OP_POLL, OP_RESET})
      else $error("high voltage held for a forbidden operation");
   chk_poll_read: assert property (
      $fell(fl_pins.oe_n) |-> op_q == OP_POLL && fl_pins.we_n && !fl_pins.dq_oe)
      else $error("status read overlaps a write");

   cov_bypass_chip: cover property (fin_q && op_q == OP_CHIP && byp_q);
   cov_block_add: cover property (fin_q && op_q == OP_ADD);
   cov_erase_suspend: cover property (fin_q && op_q == OP_ESUSP);
   cov_refused: cover property (refuse && fl_vhh_en);

endmodule

// file: include/nor_seq_cfg.svh
`ifndef NOR_SEQ_CFG_SVH
`define NOR_SEQ_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// widths
`define FL_AW 25
`define FL_DW 16

////////////////////////////////////////////////////////////////////////////////
// register port offsets
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_ADDR 8'h08
`define REG_STATUS 8'h0C
`define REG_DATA 8'h10

// control bits
`define CTRL_VHH 0
`define CTRL_UNPROT 1
`define CTRL_BYP 2
`define CTRL_RESET 3'h0

// status bits
`define ST_BUSY 0
`define ST_VHH 1
`define ST_REFUSED 2
`define ST_TMR 3
`define ST_TOG 4
`define ST_POLL 5

// positions inside the polling register
`define DQ_TMR 3
`define DQ_TOG 6
`define DQ_POLL 7

////////////////////////////////////////////////////////////////////////////////
// flash command codes and unlock addresses
`define CMD_UNLK1 16'h00AA
`define CMD_UNLK2 16'h0055
`define CMD_ERASE_SETUP 16'h0080
`define CMD_CHIP 16'h0010
`define CMD_BLOCK 16'h0030
`define CMD_SUSPEND 16'h00B0
`define CMD_RESUME 16'h0030
`define CMD_RESET 16'h00F0
`define ADR_UNLK1 25'h0000555
`define ADR_UNLK2 25'h00002AA

////////////////////////////////////////////////////////////////////////////////
// bus cycle timing, nanoseconds and derived clock counts
`define CLK_NS 4
`define T_AS_NS 10
`define T_WP_NS 35
`define T_WPH_NS 30
`define T_ACC_NS 100
`define CYC_UP(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define T_AS_CYC 8'(`CYC_UP(`T_AS_NS))
`define T_WP_CYC 8'(`CYC_UP(`T_WP_NS))
`define T_WPH_CYC 8'(`CYC_UP(`T_WPH_NS))
`define T_ACC_CYC 8'(`CYC_UP(`T_ACC_NS))

`endif

// file: include/nor_seq_pkg.sv
`include "nor_seq_cfg.svh"
package nor_seq_pkg;

   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_CHIP = 4'h1,
      OP_BLOCK = 4'h2,
      OP_ADD = 4'h3,
      OP_ESUSP = 4'h4,
      OP_RESUME = 4'h5,
      OP_PSUSP = 4'h6,
      OP_RESET = 4'h7,
      OP_POLL = 4'h8
   } op_t;

   typedef struct packed {
      logic [`FL_AW-1:0] addr;
      logic [`FL_DW-1:0] data;
      logic we;
      logic last;
   } bus_step_t;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [`FL_AW-1:0] addr;
      logic [`FL_DW-1:0] dq_o;
      logic dq_oe;
   } pins_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'h1,
      S_LAUNCH = 3'h2,
      S_WAIT = 3'h4
   } seq_state_t;

   typedef enum logic [3:0] {
      E_IDLE = 4'h1,
      E_SET = 4'h2,
      E_PULSE = 4'h4,
      E_HOLD = 4'h8
   } eng_state_t;

endpackage

// file: hdl/bus_cycle_engine.sv
`timescale 1ns/1ps
`include "nor_seq_cfg.svh"
module bus_cycle_engine (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // one bus cycle request
   input wire logic start,
   input nor_seq_pkg::bus_step_t step,
   output logic done,
   output logic [`FL_DW-1:0] rdata,
   // flash pins
   input wire logic [`FL_DW-1:0] dq_i,
   output nor_seq_pkg::pins_t pins
);
   import nor_seq_pkg::*;

   localparam pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                   addr: '0, dq_o: '0, dq_oe: 1'b0};

   eng_state_t st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   logic we_q, we_d;
   logic done_d;
   logic [`FL_DW-1:0] rdata_d;
   pins_t pins_d;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      we_d = we_q;
      pins_d = pins;
      rdata_d = rdata;
      done_d = 1'b0;
      case (st_q)
         E_IDLE: begin
            if (start) begin
               // address and chip enable settle before the strobe
               pins_d.addr = step.addr;
               pins_d.dq_o = step.data;
               pins_d.ce_n = 1'b0;
               we_d = step.we;
               cnt_d = `T_AS_CYC - 8'h01;
               st_d = E_SET;
            end
         end
         E_SET: begin
            if (cnt_q == 8'h00) begin
               pins_d.we_n = ~we_q;
               pins_d.oe_n = we_q;
               pins_d.dq_oe = we_q;
               cnt_d = we_q ? `T_WP_CYC - 8'h01 : `T_ACC_CYC - 8'h01;
               st_d = E_PULSE;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         E_PULSE: begin
            if (cnt_q == 8'h00) begin
               // device latches on the rising write strobe
               pins_d.we_n = 1'b1;
               pins_d.oe_n = 1'b1;
               if (!we_q) begin
                  rdata_d = dq_i;
               end
               cnt_d = `T_WPH_CYC - 8'h01;
               st_d = E_HOLD;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         E_HOLD: begin
            if (cnt_q == 8'h00) begin
               // data held through recovery, released with chip enable
               pins_d.ce_n = 1'b1;
               pins_d.dq_oe = 1'b0;
               done_d = 1'b1;
               st_d = E_IDLE;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         default: begin
            pins_d = PINS_IDLE;
            st_d = E_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= E_IDLE;
         cnt_q <= 8'h00;
         we_q <= 1'b0;
         pins <= PINS_IDLE;
         rdata <= '0;
         done <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         we_q <= we_d;
         pins <= pins_d;
         rdata <= rdata_d;
         done <= done_d;
      end
   end

endmodule

// file: testbench/flash_model.sv
`timescale 1ns/1ps
`include "nor_seq_cfg.svh"
module flash_model #(
   parameter int ACC_NS = 60,
   parameter logic [15:0] ARRAY_WORD = 16'h1234
) (
   // pins from the controller
   input nor_seq_pkg::pins_t pins,
   input wire logic vhh_en,
   // data toward the controller
   output logic [15:0] dq
);
   import nor_seq_pkg::*;
   logic armed = 1'b0;
   logic blk_sel = 1'b0;
   logic esusp = 1'b0;
   logic erased = 1'b0;
   logic tog = 1'b0;
   logic misuse = 1'b0;
   int busy = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // command decode on the closing edge of each write made while not busy; unlock pairs are not
   // checked, so high voltage and plain bypass look the same here
   always @(posedge pins.we_n) begin
      // high voltage is only for the chip erase codes and read/reset
      if (!pins.ce_n && vhh_en &&
          !(pins.dq_o[7:0] inside {8'h80, 8'h10, 8'hF0})) begin
         misuse = 1'b1;
      end
      if (!pins.ce_n && busy == 0) begin
         case (pins.dq_o[7:0])
            8'hAA, 8'h55: armed = armed;
            8'h80: armed = 1'b1;
            8'h10: if (armed) begin
               busy = 2;
               erased = 1'b1;
               armed = 1'b0;
            end
            8'h30: if (armed || blk_sel) begin
               blk_sel = 1'b1;
               armed = 1'b0;
            end else if (esusp) begin
               esusp = 1'b0;
               blk_sel = 1'b1;
            end
            8'hB0: if (blk_sel) begin
               esusp = 1'b1;
               blk_sel = 1'b0;
            end
            default: begin
               armed = 1'b0;
               blk_sel = 1'b0;
            end
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // reads: garbage until access time, polling word while busy
   // one process owns the lines; a released bus must not keep the last value
   always @(pins.oe_n) begin
      dq = ~dq;
      if (!pins.oe_n) begin
         #(ACC_NS);
         if (busy > 0) begin
            tog = ~tog;
            busy--;
            dq = {8'h00, 1'b0, tog, 2'b00, 1'b1, 3'b000};
         end else if (blk_sel || esusp) begin
            dq = {8'h00, 1'b0, tog, 6'h00};
         end else begin
            dq = erased ? 16'hFFFF : ARRAY_WORD;
         end
      end
   end
endmodule

// file: testbench/tb_nor_erase_suspend_sequencer.sv
`timescale 1ns/1ps
`include "nor_seq_cfg.svh"
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin mismatches++; $display("FAIL %0t %s", $time, m); end end
module tb_nor_erase_suspend_sequencer;
   import nor_seq_pkg::*;
   typedef struct {logic [24:0] a; logic [15:0] d; bit ca;} fw_t;
   typedef struct {logic [31:0] v; logic [31:0] m;} rd_t;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [15:0] fl_dq_i;
   logic [15:0] mdl_dq;
   pins_t fl_pins;
   logic fl_vhh_en;
   logic rd_d1 = 1'b0;
   logic we_d1 = 1'b1;
   int mismatches = 0;
   int samples_checked = 0;
   int seed = 32'h58AB;
   int wp_cnt = 0;
   logic [31:0] r;
   logic [31:0] blk;
   fw_t wr_q[$];
   rd_t rd_q[$];
   fw_t we;
   rd_t re;
   logic [15:0] pw[3] = '{16'h0048, 16'h0008, 16'hFFFF};
   logic [31:0] sb[3] = '{32'h18, 32'h08, 32'h38};
   logic [15:0] code[4] = '{`CMD_SUSPEND, `CMD_RESUME, `CMD_SUSPEND, `CMD_RESET};

   initial forever #2 mclk = ~mclk;
   // wire level of the shared data lines
   assign fl_dq_i = fl_pins.dq_oe ? fl_pins.dq_o : mdl_dq;

   nor_erase_suspend_sequencer u_nor_erase_suspend_sequencer (.mclk(mclk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .fl_dq_i(fl_dq_i), .fl_pins(fl_pins), .fl_vhh_en(fl_vhh_en));
   flash_model u_flash_model (.pins(fl_pins), .vhh_en(fl_vhh_en), .dq(mdl_dq));

   ////////////////////////////////////////////////////////////////////////////////
   task give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task reg_w(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // mask 0 means the read is only a peek
   task reg_r(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
              output logic [31:0] v);
      rd_q.push_back('{e, m});
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task push_w(input logic [24:0] a, input logic [15:0] d, input bit ca);
      wr_q.push_back('{a, d, ca});
   endtask
   task exp_seq(input logic [15:0] fin, input logic [24:0] fa, input bit byp);
      for (int i = 0; i < 2; i++) begin
         if (!byp) begin
            push_w(`ADR_UNLK1, `CMD_UNLK1, 1'b1);
            push_w(`ADR_UNLK2, `CMD_UNLK2, 1'b1);
         end
         if (i == 0) push_w(`ADR_UNLK1, `CMD_ERASE_SETUP, 1'b1);
      end
      push_w(fa, fin, 1'b1);
   endtask
   task wait_idle;
      int n;
      logic [31:0] v;
      n = 0;
      do begin
         reg_r(`REG_STATUS, 32'h0, 32'h0, v);
         n++;
      end while (v[`ST_BUSY] !== 1'b0 && n < 400);
      if (n >= 400) begin
         mismatches++;
         $display("FAIL %0t busy never cleared", $time);
         give_verdict();
      end else begin
         `CHK(wr_q.size(), 0, "flash writes missing")
      end
   endtask
   task run_op(input logic [3:0] op);
      reg_w(`REG_CMD, {28'h0, op});
      wait_idle();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // watcher: register reads and flash write cycles against the notes
   always @(posedge mclk) begin
      rd_d1 <= reg_rd;
      we_d1 <= fl_pins.we_n;
      wp_cnt <= (!fl_pins.we_n && rst_n) ? wp_cnt + 1 : 0;
      if (rd_d1 && rd_q.size() > 0) begin
         re = rd_q.pop_front();
         if (re.m != 32'h0) `CHK(reg_rdata & re.m, re.v & re.m, "register read")
      end
      if (fl_pins.we_n && !we_d1 && rst_n) begin
         `CHK(wp_cnt, int'(`T_WP_CYC), "write pulse width")
         if (wr_q.size() == 0) `CHK(1'b1, 1'b0, "unexpected flash write")
         else begin
            we = wr_q.pop_front();
            `CHK(fl_pins.dq_o, we.d, "flash write data")
            if (we.ca) `CHK(fl_pins.addr, we.a, "flash write address")
         end
      end
   end

   initial begin
      #300000;
      mismatches++;
      $display("FAIL %0t run hung", $time);
      give_verdict();
   end

   initial begin
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      reg_r(`REG_CTRL, 32'h0, '1, r);
      reg_r(`REG_STATUS, 32'h0, '1, r);
      reg_w(8'h20, '1);
      reg_r(8'h20, 32'h0, '1, r);
      $display("test reset done");
      // chip erase, then a second order while busy is refused
      r = $random(seed);
      reg_w(`REG_ADDR, {7'h0, r[24:0]});
      exp_seq(`CMD_CHIP, `ADR_UNLK1, 1'b0);
      reg_w(`REG_CMD, 32'h1);
      reg_w(`REG_CMD, 32'h2);
      wait_idle();
      reg_r(`REG_STATUS, 32'h4, 32'h4, r);
      reg_r(`REG_CMD, 32'h1, 32'hF, r);
      reg_w(`REG_STATUS, 32'h4);
      reg_r(`REG_STATUS, 32'h0, 32'h4, r);
      // polling word while erasing, all ones afterwards
      for (int i = 0; i < 3; i++) begin
         run_op(4'h8);
         reg_r(`REG_DATA, {16'h0, pw[i]}, 32'hFFFF, r);
         reg_r(`REG_STATUS, sb[i], 32'h38, r);
      end
      $display("test chip erase done");
      // block list, suspend, resume, read/reset
      r = $random(seed);
      blk = {7'h0, r[24:0]};
      reg_w(`REG_ADDR, blk);
      exp_seq(`CMD_BLOCK, blk[24:0], 1'b0);
      run_op(4'h2);
      r = $random(seed);
      reg_w(`REG_ADDR, {7'h0, r[24:0]});
      push_w(r[24:0], `CMD_BLOCK, 1'b1);
      run_op(4'h3);
      for (int k = 0; k < 4; k++) begin
         push_w(25'h0, code[k], 1'b0);
         run_op(4'(k + 4));
      end
      $display("test block erase done");
      // bypass shortcuts
      reg_w(`REG_ADDR, blk);
      reg_w(`REG_CTRL, 32'h4);
      exp_seq(`CMD_CHIP, `ADR_UNLK1, 1'b1);
      run_op(4'h1);
      exp_seq(`CMD_BLOCK, blk[24:0], 1'b1);
      run_op(4'h2);
      reg_w(`REG_CTRL, 32'h0);
      $display("test bypass done");
      // high voltage only with confirmed unprotected blocks
      reg_w(`REG_CTRL, 32'h1);
      repeat (4) @(posedge mclk);
      `CHK(fl_vhh_en, 1'b0, "high voltage without confirmation")
      reg_w(`REG_CTRL, 32'h3);
      repeat (4) @(posedge mclk);
      `CHK(fl_vhh_en, 1'b1, "high voltage request")
      reg_w(`REG_CMD, 32'h2);
      wait_idle();
      reg_r(`REG_STATUS, 32'h6, 32'h6, r);
      exp_seq(`CMD_CHIP, `ADR_UNLK1, 1'b1);
      run_op(4'h1);
      `CHK(u_flash_model.misuse, 1'b0, "high voltage misuse")
      reg_w(`REG_CTRL, 32'h0);
      repeat (4) @(posedge mclk);
      `CHK(fl_vhh_en, 1'b0, "high voltage removed")
      $display("test high voltage done");
      // reset in mid-sequence abandons it
      exp_seq(`CMD_CHIP, `ADR_UNLK1, 1'b0);
      reg_w(`REG_CMD, 32'h1);
      repeat (40) @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      wr_q.delete();
      `CHK({fl_pins.ce_n, fl_pins.we_n, fl_pins.dq_oe}, 3'b110, "pins after reset")
      `CHK(fl_pins.oe_n, 1'b1, "read strobe after reset")
      rst_n <= 1'b1;
      reg_r(`REG_STATUS, 32'h0, 32'h1, r);
      repeat (40) @(posedge mclk);
      `CHK(fl_pins.ce_n, 1'b1, "no bus cycle after reset")
      $display("test reset in flight done");
      give_verdict();
   end
endmodule
